// [design/dzb_map.svh]
// Register offsets, opcodes and coded values of the decimal and bit datapath
`ifndef DZB_MAP_SVH
`define DZB_MAP_SVH
`define DZB_A_CMD 5'h00
`define DZB_A_BASE1 5'h01
`define DZB_A_BASE2 5'h02
`define DZB_A_LENS 5'h03
`define DZB_A_STAT 5'h04
`define DZB_A_COND 5'h05
`define DZB_A_GPR 2'h1
`define DZB_OP_ZADD 8'h50
`define DZB_OP_INV 8'hBF
`define DZB_OP_SET 8'hB3
`define DZB_OP_SCZ 8'h6F
`define DZB_OP_SCO 8'h6D
`define DZB_CC_OVF 8'h80
`define DZB_CC_POS 8'h44
`define DZB_CC_NEG 8'h22
`define DZB_CC_ZERO 8'h11
`define DZB_SG_POS 4'hC
`define DZB_SG_NEG 4'hD
`define DZB_SG_NEG2 4'hB
`define DZB_NOT_FOUND 5'h10
`define DZB_PD_IDLE 2'h0
`define DZB_PD_WAIT 2'h1
`define DZB_PD_DATA 2'h2
`endif

// [design/dzb_pkg.sv]
// Types of the decimal zero-and-add and bit operation datapath
package dzb_pkg;
   typedef enum logic [11:0] {
      S_IDLE = 12'h001,
      S_IND = 12'h002,
      S_BRD = 12'h004,
      S_BWR = 12'h008,
      S_ZCLR = 12'h010,
      S_ZSCN = 12'h020,
      S_ZWRT = 12'h040,
      S_OP1 = 12'h080,
      S_OP2 = 12'h100,
      S_WR1 = 12'h200,
      S_WR2 = 12'h400,
      S_FIN = 12'h800
   } dzb_state_t;
   typedef struct packed {
      logic ixEn2;
      logic ixEn1;
      logic [7:0] opcode;
      logic i1;
      logic [2:0] r1;
      logic i2;
      logic [2:0] r2;
   } dzb_cmd_t;
   typedef struct packed {
      logic re;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dzb_mem_req_t;
   typedef struct packed {
      dzb_state_t st;
      dzb_cmd_t cmd;
      logic [15:0] base1;
      logic [15:0] base2;
      logic [7:0] len1;
      logic [7:0] len2;
      logic [7:0] cond;
      logic [7:0][15:0] gpr;
      logic busy;
      logic done;
      logic [15:0] ea1;
      logic [15:0] ea2;
      logic [8:0] k;
      logic [1:0] pend;
      logic hi;
      logic [15:0] word1;
      logic [15:0] word2;
      logic [4:0] pos;
      logic nzIn;
      logic nzOut;
      logic [3:0] srcSign;
      dzb_mem_req_t memReq;
      logic [31:0] rdata;
   } dzb_state_s_t;
endpackage

// [design/dzb_datapath.sv]
// Zero-and-add decimal and bit manipulation execution datapath
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "dzb_map.svh"
// Notes on behaviour
// - Source and destination lengths 0-255 bytes; addresses point at most significant byte.
// - Zero-and-add addresses may be indexed, never indirect.
// - Destination is cleared first, then the source is added into it.
// - Significant excess source digits set condition bit 0, clear bits 1-7.
// - Zero source length adds zero; both lengths zero gives bits 3 and 7.
// - Missing high-order source digits are taken as zero.
// - Condition bits 1,5 plus; 2,6 minus; 3,7 zero; others cleared.
// - Result sign nibble is C when positive, D when negative.
// - No negative zero result unless overflow occurred.
// - Source digits are not checked; invalid digits give undefined results.
// - Bit number is instruction bits 13-15, 0 leftmost, 7 rightmost.
// - Invert opcode reads the byte, toggles the bit, writes it back.
// - Set operation forces the bit to one and writes the byte back.
// - Byte operand address may be indexed, indirect, or both.
// - Opcode 6F finds first zero bit, sets it, adds position to second word.
// - Nothing found: add 16 and leave the scanned word unchanged.
// - Opcode 6D finds first one bit, clears it, adds position to second word.
// - Scan operands are the register, or memory at its address when indirect.
// - Same register, same mode: only the incremented value is returned.
// - Same register, scanned indirect, incremented direct: both results normal.
// - Same register, scanned direct: flipped word to register, then sum at it.
module dzb_datapath (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output dzb_pkg::dzb_mem_req_t memReq,
   input wire logic [7:0] memRdata,
   output logic busy,
   output logic done
);
   dzb_pkg::dzb_state_s_t s;
   dzb_pkg::dzb_state_s_t n;

   function automatic logic [4:0] firstPos(input logic [15:0] w, input logic want);
      logic [4:0] p;
      p = `DZB_NOT_FOUND;
      for (int i = 0; i < 16; i++) begin
         if (w[i] == want) begin
            p = 5'(15 - i);
         end
      end
      return p;
   endfunction

   function automatic logic [7:0] bitMask(input logic [2:0] p);
      return 8'h80 >> p;
   endfunction

   function automatic logic [15:0] idx(input logic [15:0] b, input logic en, input logic [15:0] v);
      return en ? b + v : b;
   endfunction

   // Byte k counted from the least significant end of a field
   function automatic logic [15:0] byteAt(input logic [15:0] ea, input logic [7:0] len,
                                          input logic [8:0] k);
      return ea + {8'h00, len} - 16'h0001 - {7'h00, k};
   endfunction

   function automatic logic isNeg(input logic [3:0] sg);
      return sg == `DZB_SG_NEG || sg == `DZB_SG_NEG2;
   endfunction

   assign regRdata = s.rdata;
   assign memReq = s.memReq;
   assign busy = s.busy;
   assign done = s.done;

   always_comb begin
      dzb_pkg::dzb_cmd_t c;
      logic rdReq;
      logic [15:0] rdAddr;
      logic go;
      logic [15:0] w;
      logic [7:0] b;
      logic negR;
      logic same;
      c = dzb_pkg::dzb_cmd_t'(regWdata[17:0]);
      rdReq = 1'b0;
      rdAddr = s.ea1;
      go = 1'b0;
      w = 16'h0000;
      b = 8'h00;
      negR = isNeg(s.srcSign) && s.len1 != 8'h00;
      same = s.cmd.r1 == s.cmd.r2;
      n = s;
      n.memReq.re = 1'b0;
      n.memReq.we = 1'b0;
      n.done = 1'b0;
      n.rdata = 32'h0000_0000;
      if (regRd) begin
         case (regAddr)
            `DZB_A_CMD: n.rdata = {14'h0000, s.cmd};
            `DZB_A_BASE1: n.rdata = {16'h0000, s.base1};
            `DZB_A_BASE2: n.rdata = {16'h0000, s.base2};
            `DZB_A_LENS: n.rdata = {16'h0000, s.len2, s.len1};
            `DZB_A_STAT: n.rdata = {16'h0000, s.cond, 7'h00, s.busy};
            `DZB_A_COND: n.rdata = {24'h000000, s.cond};
            default: begin
               if (regAddr[4:3] == `DZB_A_GPR) begin
                  n.rdata = {16'h0000, s.gpr[regAddr[2:0]]};
               end
            end
         endcase
      end
      // Writes are dropped while an operation runs so operands cannot shift under it
      if (regWr && !s.busy) begin
         case (regAddr)
            `DZB_A_CMD: begin
               n.cmd = c;
               n.busy = 1'b1;
               n.k = 9'h000;
               n.pend = `DZB_PD_IDLE;
               n.hi = 1'b0;
               n.nzIn = 1'b0;
               n.nzOut = 1'b0;
               n.srcSign = `DZB_SG_POS;
               n.ea1 = idx(s.base1, c.ixEn1, s.gpr[c.r1]);
               n.ea2 = idx(s.base2, c.ixEn2, s.gpr[c.r2]);
               case (c.opcode)
                  `DZB_OP_ZADD: n.st = dzb_pkg::S_ZCLR;
                  `DZB_OP_INV, `DZB_OP_SET: n.st = c.i1 ? dzb_pkg::S_IND : dzb_pkg::S_BRD;
                  `DZB_OP_SCZ, `DZB_OP_SCO: begin
                     n.ea1 = s.gpr[c.r1];
                     n.ea2 = s.gpr[c.r2];
                     n.st = dzb_pkg::S_OP1;
                  end
                  default: n.st = dzb_pkg::S_FIN;
               endcase
            end
            `DZB_A_BASE1: n.base1 = regWdata[15:0];
            `DZB_A_BASE2: n.base2 = regWdata[15:0];
            `DZB_A_LENS: begin
               n.len1 = regWdata[7:0];
               n.len2 = regWdata[15:8];
            end
            `DZB_A_COND: n.cond = regWdata[7:0];
            default: begin
               if (regAddr[4:3] == `DZB_A_GPR) begin
                  n.gpr[regAddr[2:0]] = regWdata[15:0];
               end
            end
         endcase
      end
      case (s.st)
         dzb_pkg::S_IDLE: begin
         end
         dzb_pkg::S_IND: begin
            rdReq = 1'b1;
            rdAddr = s.ea1 + {15'h0000, s.hi};
            if (s.pend == `DZB_PD_DATA) begin
               n.hi = !s.hi;
               if (!s.hi) begin
                  n.word1[15:8] = memRdata;
               end else begin
                  n.ea1 = {s.word1[15:8], memRdata};
                  n.st = dzb_pkg::S_BRD;
               end
            end
         end
         dzb_pkg::S_BRD: begin
            rdReq = 1'b1;
            if (s.pend == `DZB_PD_DATA) begin
               n.word1[7:0] = memRdata;
               n.st = dzb_pkg::S_BWR;
            end
         end
         dzb_pkg::S_BWR: begin
            n.memReq.we = 1'b1;
            n.memReq.addr = s.ea1;
            if (s.cmd.opcode == `DZB_OP_INV) begin
               n.memReq.wdata = s.word1[7:0] ^ bitMask(s.cmd.r2);
            end else begin
               n.memReq.wdata = s.word1[7:0] | bitMask(s.cmd.r2);
            end
            n.st = dzb_pkg::S_FIN;
         end
         dzb_pkg::S_ZCLR: begin
            if (s.k < {1'b0, s.len2}) begin
               n.memReq.we = 1'b1;
               n.memReq.addr = byteAt(s.ea2, s.len2, s.k);
               n.memReq.wdata = 8'h00;
               n.k = s.k + 9'h001;
            end else begin
               n.k = 9'h000;
               n.st = dzb_pkg::S_ZSCN;
            end
         end
         dzb_pkg::S_ZSCN: begin
            // A first pass finds zero and overflow before any sign is written
            if (s.k < {1'b0, s.len1}) begin
               rdReq = 1'b1;
               rdAddr = byteAt(s.ea1, s.len1, s.k);
               if (s.pend == `DZB_PD_DATA) begin
                  b = memRdata;
                  if (s.k == 9'h000) begin
                     n.srcSign = b[3:0];
                     b[3:0] = 4'h0;
                  end
                  if (s.k < {1'b0, s.len2}) begin
                     n.nzIn = s.nzIn || b != 8'h00;
                  end else begin
                     n.nzOut = s.nzOut || b != 8'h00;
                  end
                  n.k = s.k + 9'h001;
               end
            end else begin
               n.k = 9'h000;
               n.st = dzb_pkg::S_ZWRT;
            end
         end
         dzb_pkg::S_ZWRT: begin
            if (s.k < {1'b0, s.len2}) begin
               rdReq = s.k < {1'b0, s.len1};
               rdAddr = byteAt(s.ea1, s.len1, s.k);
               go = !rdReq || s.pend == `DZB_PD_DATA;
               b = rdReq ? memRdata : 8'h00;
               if (s.k == 9'h000) begin
                  // Digits are copied unchecked; bad nibbles pass straight through
                  b[3:0] = (negR && (s.nzIn || s.nzOut)) ? `DZB_SG_NEG : `DZB_SG_POS;
               end
               if (go) begin
                  n.memReq.we = 1'b1;
                  n.memReq.addr = byteAt(s.ea2, s.len2, s.k);
                  n.memReq.wdata = b;
                  n.k = s.k + 9'h001;
               end
            end else begin
               if (s.nzOut) begin
                  n.cond = `DZB_CC_OVF;
               end else if (!s.nzIn) begin
                  n.cond = `DZB_CC_ZERO;
               end else begin
                  n.cond = negR ? `DZB_CC_NEG : `DZB_CC_POS;
               end
               n.st = dzb_pkg::S_FIN;
            end
         end
         dzb_pkg::S_OP1: begin
            w = s.gpr[s.cmd.r1];
            go = !s.cmd.i1;
            if (s.cmd.i1) begin
               rdReq = 1'b1;
               rdAddr = s.ea1 + {15'h0000, s.hi};
               if (s.pend == `DZB_PD_DATA) begin
                  n.hi = !s.hi;
                  n.word1[15:8] = memRdata;
                  w = {s.word1[15:8], memRdata};
                  go = s.hi;
               end
            end
            if (go) begin
               n.word1 = w;
               n.st = dzb_pkg::S_OP2;
            end
         end
         dzb_pkg::S_OP2: begin
            w = s.gpr[s.cmd.r2];
            go = !s.cmd.i2;
            if (s.cmd.i2) begin
               rdReq = 1'b1;
               rdAddr = s.ea2 + {15'h0000, s.hi};
               if (s.pend == `DZB_PD_DATA) begin
                  n.hi = !s.hi;
                  n.word2[15:8] = memRdata;
                  w = {s.word2[15:8], memRdata};
                  go = s.hi;
               end
            end
            if (go) begin
               n.word2 = w;
               n.pos = firstPos(s.word1, s.cmd.opcode == `DZB_OP_SCO);
               if ((same && s.cmd.i1 == s.cmd.i2) ||
                   firstPos(s.word1, s.cmd.opcode == `DZB_OP_SCO) == `DZB_NOT_FOUND) begin
                  n.st = dzb_pkg::S_WR2;
               end else begin
                  n.st = dzb_pkg::S_WR1;
               end
            end
         end
         dzb_pkg::S_WR1: begin
            w = s.word1 ^ (16'h8000 >> s.pos);
            if (!s.cmd.i1) begin
               n.gpr[s.cmd.r1] = w;
               if (same) begin
                  n.ea2 = w;
               end
               n.st = dzb_pkg::S_WR2;
            end else begin
               n.memReq.we = 1'b1;
               n.memReq.addr = s.ea1 + {15'h0000, s.hi};
               n.memReq.wdata = s.hi ? w[7:0] : w[15:8];
               n.hi = !s.hi;
               if (s.hi) begin
                  n.st = dzb_pkg::S_WR2;
               end
            end
         end
         dzb_pkg::S_WR2: begin
            w = s.word2 + {11'h000, s.pos};
            if (!s.cmd.i2) begin
               n.gpr[s.cmd.r2] = w;
               n.st = dzb_pkg::S_FIN;
            end else begin
               n.memReq.we = 1'b1;
               n.memReq.addr = s.ea2 + {15'h0000, s.hi};
               n.memReq.wdata = s.hi ? w[7:0] : w[15:8];
               n.hi = !s.hi;
               if (s.hi) begin
                  n.st = dzb_pkg::S_FIN;
               end
            end
         end
         dzb_pkg::S_FIN: begin
            n.busy = 1'b0;
            n.done = 1'b1;
            n.st = dzb_pkg::S_IDLE;
         end
         default: n.st = dzb_pkg::S_IDLE;
      endcase
      // Storage answers one cycle after it samples the read strobe
      if (rdReq) begin
         case (s.pend)
            `DZB_PD_IDLE: begin
               n.memReq.re = 1'b1;
               n.memReq.addr = rdAddr;
               n.pend = `DZB_PD_WAIT;
            end
            `DZB_PD_WAIT: n.pend = `DZB_PD_DATA;
            default: n.pend = `DZB_PD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '{st: dzb_pkg::S_IDLE, default: '0};
      end else begin
         s <= n;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence zaddEnd;
      s.st == dzb_pkg::S_FIN && s.cmd.opcode == `DZB_OP_ZADD;
   endsequence
   sequence signWr;
      memReq.we && $past(s.st == dzb_pkg::S_ZWRT && s.k == 9'h000);
   endsequence

   property p_inv_bit;
      s.st == dzb_pkg::S_BWR && s.cmd.opcode == `DZB_OP_INV |=>
         memReq.we && memReq.wdata == ($past(s.word1[7:0]) ^ bitMask($past(s.cmd.r2)));
   endproperty
   a_inv_bit: assert property (p_inv_bit)
      else $error("inverted byte is wrong");
   property p_set_bit;
      s.st == dzb_pkg::S_BWR && s.cmd.opcode == `DZB_OP_SET |=>
         memReq.we && memReq.addr == $past(s.ea1) &&
         memReq.wdata == ($past(s.word1[7:0]) | bitMask($past(s.cmd.r2)));
   endproperty
   a_set_bit: assert property (p_set_bit)
      else $error("set byte is wrong");
   property p_clear_first;
      s.st == dzb_pkg::S_ZCLR && s.k < {1'b0, s.len2} |=> memReq.we && memReq.wdata == 8'h00;
   endproperty
   a_clear_first: assert property (p_clear_first)
      else $error("destination not cleared");
   property p_cond_result;
      zaddEnd and (!s.nzOut) |-> s.cond inside {`DZB_CC_POS, `DZB_CC_NEG, `DZB_CC_ZERO};
   endproperty
   a_cond_result: assert property (p_cond_result)
      else $error("bad result condition");
   property p_cond_ovf;
      zaddEnd and s.nzOut |-> s.cond == `DZB_CC_OVF;
   endproperty
   a_cond_ovf: assert property (p_cond_ovf)
      else $error("overflow condition missing");
   property p_both_zero;
      regWr && !s.busy && regAddr == `DZB_A_CMD && regWdata[15:8] == `DZB_OP_ZADD &&
         s.len1 == 8'h00 && s.len2 == 8'h00 |-> ##4 zaddEnd ##1 s.cond == `DZB_CC_ZERO;
   endproperty
   a_both_zero: assert property (p_both_zero)
      else $error("zero lengths gave wrong condition");
   property p_sign_code;
      signWr |-> memReq.wdata[3:0] inside {`DZB_SG_POS, `DZB_SG_NEG};
   endproperty
   a_sign_code: assert property (p_sign_code)
      else $error("bad sign nibble");
   property p_no_neg_zero;
      signWr and (!s.nzIn && !s.nzOut) |-> memReq.wdata[3:0] == `DZB_SG_POS;
   endproperty
   a_no_neg_zero: assert property (p_no_neg_zero)
      else $error("negative zero produced");
   property p_cond_kept;
      s.busy && s.cmd.opcode != `DZB_OP_ZADD |=> $stable(s.cond);
   endproperty
   a_cond_kept: assert property (p_cond_kept)
      else $error("bit operation touched condition");
   property p_no_flip;
      s.st == dzb_pkg::S_WR1 |-> s.pos != `DZB_NOT_FOUND &&
         !(s.cmd.r1 == s.cmd.r2 && s.cmd.i1 == s.cmd.i2);
   endproperty
   a_no_flip: assert property (p_no_flip)
      else $error("scanned word flipped when it must not be");
endmodule

// [bench/dzb_storage_model.sv]
// Byte-wide main storage standing on the far side of the datapath
`timescale 1ns/1ps
module dzb_storage_model (
   input wire logic clk,
   input wire dzb_pkg::dzb_mem_req_t memReq,
   output logic [7:0] memRdata
);
   logic [7:0] mem [0:65535];

   initial memRdata = 8'h00;

   // Data stand only in the cycle after the read strobe; otherwise the line wanders
   always @(posedge clk) begin
      if (memReq.we)
         mem[memReq.addr] <= memReq.wdata;
      memRdata <= memReq.re ? mem[memReq.addr] : ~memRdata;
   end
endmodule

// [bench/decimal_zero_add_bit_ops_tb.sv]
// Self-checking bench of the decimal zero-and-add and bit datapath
`timescale 1ns/1ps
module decimal_zero_add_bit_ops_tb;
   logic clk;
   logic rst;
   logic [4:0] regAddr;
   logic [31:0] regWdata;
   logic regWr;
   logic regRd;
   logic [31:0] regRdata;
   dzb_pkg::dzb_mem_req_t memReq;
   logic [7:0] memRdata;
   logic busy;
   logic done;
   int fails;
   int totalChecks;
   int cycles;
   logic [31:0] seed;
   logic [7:0] sh [0:65535];
   logic [15:0] gx [0:7];
   logic [7:0] cx;
   int c1 [6] = '{0, 3, 0, 4, 2, 255};
   int c2 [6] = '{0, 0, 3, 2, 5, 254};

   dzb_datapath dzb_datapath_inst (
      .clk(clk),
      .rst(rst),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regWr(regWr),
      .regRd(regRd),
      .regRdata(regRdata),
      .memReq(memReq),
      .memRdata(memRdata),
      .busy(busy),
      .done(done)
   );
   dzb_storage_model dzb_storage_model_inst (
      .clk(clk),
      .memReq(memReq),
      .memRdata(memRdata)
   );

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   // Whole run needs some 3500 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [15:0] rnd();
      repeat (16) seed = lfsr(seed);
      return seed[15:0];
   endfunction

   function automatic logic [4:0] scan(input logic [15:0] w, input logic one);
      for (int i = 0; i < 16; i++)
         if (w[15 - i] == one)
            return 5'(i);
      return 5'h10;
   endfunction

   // Nibble n of a packed field counted from the sign (-1) upward
   function automatic logic [3:0] srcNib(input logic [15:0] e, input int l, input int n);
      logic [7:0] b;
      if (n >= 2 * l - 1)
         return 4'h0;
      b = sh[e + 16'(l - 1 - (n + 1) / 2)];
      return n[0] ? b[3:0] : b[7:4];
   endfunction

   function automatic logic [15:0] rdw(input logic [15:0] a);
      return {sh[a], sh[a + 16'h0001]};
   endfunction

   task automatic wrw(input logic [15:0] a, input logic [15:0] v);
      sh[a] = v[15:8];
      sh[a + 16'h0001] = v[7:0];
   endtask

   task automatic poke(input logic [15:0] a, input logic [7:0] b);
      sh[a] = b;
      dzb_storage_model_inst.mem[a] = b;
   endtask

   task automatic wrReg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge clk);
      regWr <= 1'h0;
   endtask

   task automatic rdReg(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk);
      regRd <= 1'h0;
      #1 d = regRdata;
   endtask

   task automatic setGpr(input logic [2:0] r, input logic [15:0] v);
      gx[r] = v;
      wrReg({2'h1, r}, {16'h0000, v});
   endtask

   // The global cycle ceiling bounds this wait
   task automatic runOp(input logic [31:0] c);
      wrReg(5'h00, c);
      #1 check({31'h0, busy}, 32'h1);
      while (done !== 1'h1)
         @(posedge clk);
      #1 check({31'h0, busy}, 32'h0);
      @(posedge clk);
   endtask

   task automatic verify();
      logic [31:0] d;
      int bad;
      for (int r = 0; r < 8; r++) begin
         rdReg({2'h1, 3'(r)}, d);
         check(d, {16'h0000, gx[r]});
      end
      rdReg(5'h05, d);
      check(d, {24'h000000, cx});
      rdReg(5'h06, d);
      check(d, 32'h0);
      rdReg(5'h04, d);
      check(d, {16'h0000, cx, 8'h00});
      bad = 0;
      for (int a = 0; a < 65536; a++)
         if (dzb_storage_model_inst.mem[a] !== sh[a])
            bad++;
      check(32'(bad), 32'h0);
   endtask

   initial begin
      logic [15:0] v, p, ea, a1, a2, op1, op2, fl, sum;
      logic [7:0] op, m;
      logic [4:0] pos;
      logic [2:0] r1, r2;
      logic i1, i2, same, neg, ovf, zr;
      int l1, l2, k;
      fails = 0;
      totalChecks = 0;
      cycles = 0;
      seed = 32'h0001_6153;
      rst = 1'h1;
      regAddr = 5'h00;
      regWdata = 32'h0;
      regWr = 1'h0;
      regRd = 1'h0;
      cx = 8'h00;
      for (int r = 0; r < 8; r++)
         gx[r] = 16'h0000;
      for (int a = 0; a < 65536; a++) begin
         v = rnd();
         poke(16'(a), v[7:0]);
      end
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      verify();
      // Byte bit operations over all four addressing forms
      for (int t = 0; t < 8; t++) begin
         op = t[0] ? 8'hB3 : 8'hBF;
         v = rnd();
         r1 = v[2:0];
         setGpr(r1, {9'h000, v[14:8]});
         p = 16'h0100 + {9'h000, v[6:0]};
         wrReg(5'h01, {16'h0000, p});
         ea = t[1] ? p + gx[r1] : p;
         if (t[2]) begin
            v = rnd();
            poke(ea, 8'h03);
            poke(ea + 16'h0001, v[7:0]);
            ea = {8'h03, v[7:0]};
         end
         v = rnd();
         cx = v[15:8];
         wrReg(5'h05, {24'h000000, cx});
         m = 8'h80 >> v[2:0];
         sh[ea] = t[0] ? sh[ea] | m : sh[ea] ^ m;
         runOp({14'h0000, 1'h0, t[1], op, t[2], r1, 1'h0, v[2:0]});
         verify();
      end
      // Scans: every mode pair, distinct and shared registers
      for (int t = 0; t < 16; t++) begin
         op = t[3] ? 8'h6D : 8'h6F;
         i1 = t[0];
         i2 = t[1];
         same = t[2];
         v = rnd();
         r1 = v[2:0];
         r2 = same ? r1 : r1 + 3'h1;
         a1 = {11'h030, r1, 2'h0};
         a2 = {11'h030, r2, 2'h0};
         for (int j = 0; j < 2; j++) begin
            v = rnd();
            poke(a1 + 16'(j), v[7:0]);
            poke(a2 + 16'(j), v[15:8]);
         end
         v = rnd();
         if (t[2:0] == 3'h0)
            v = t[3] ? 16'h0000 : 16'hFFFF;
         if (i1) begin
            poke(a1, v[15:8]);
            poke(a1 + 16'h0001, v[7:0]);
         end
         setGpr(r1, (i1 | (same & i2)) ? a1 : v);
         if (!same) begin
            p = rnd();
            setGpr(r2, i2 ? a2 : p);
         end
         op1 = i1 ? rdw(gx[r1]) : gx[r1];
         op2 = i2 ? rdw(gx[r2]) : gx[r2];
         pos = scan(op1, t[3]);
         fl = pos[4] ? op1 : op1 ^ (16'h8000 >> pos);
         sum = op2 + {11'h000, pos};
         a1 = gx[r1];
         a2 = gx[r2];
         if (same && i1 == i2) begin
            if (i1)
               wrw(a1, sum);
            else
               gx[r1] = sum;
         end else if (same && !i1) begin
            gx[r1] = fl;
            wrw(fl, sum);
         end else begin
            if (i1)
               wrw(a1, fl);
            else
               gx[r1] = fl;
            if (i2)
               wrw(a2, sum);
            else
               gx[r2] = sum;
         end
         runOp({16'h0000, op, i1, r1, i2, r2});
         verify();
      end
      // Zero-and-add: length corners, then random lengths and signs
      for (int t = 0; t < 12; t++) begin
         v = rnd();
         l1 = t < 6 ? c1[t] : int'(v[2:0]);
         l2 = t < 6 ? c2[t] : int'(v[5:3]);
         r1 = v[8:6];
         r2 = v[11:9];
         setGpr(r1, {12'h000, v[15:12]});
         setGpr(r2, {12'h000, v[15:12] ^ 4'h5});
         v = rnd();
         a1 = 16'h0300 + {8'h00, v[7:0]};
         a2 = 16'h0800 + {8'h00, v[15:8]};
         wrReg(5'h01, {16'h0000, a1});
         wrReg(5'h02, {16'h0000, a2});
         wrReg(5'h03, {16'h0000, 8'(l2), 8'(l1)});
         if (t[0])
            a1 = a1 + gx[r1];
         if (t[1])
            a2 = a2 + gx[r2];
         neg = v[0] | (t == 6);
         for (int j = 0; j < l1; j++) begin
            v = rnd();
            if (t == 6)
               v = 16'h0000;
            // Only valid digits, since other codes give no defined sum
            m = {v[7:4] % 4'hA, (j == l1 - 1) ? (neg ? 4'hD : 4'hC) : v[3:0] % 4'hA};
            poke(a1 + 16'(j), m);
         end
         ovf = 1'h0;
         zr = 1'h1;
         for (int n = 0; n < 2 * l1 - 1; n++)
            if (srcNib(a1, l1, n) != 4'h0) begin
               if (n >= 2 * l2 - 1)
                  ovf = 1'h1;
               else
                  zr = 1'h0;
            end
         neg = l1 > 0 && neg;
         cx = ovf ? 8'h80 : zr ? 8'h11 : neg ? 8'h22 : 8'h44;
         for (int j = 0; j < l2; j++) begin
            k = l2 - 1 - j;
            m[7:4] = srcNib(a1, l1, 2 * k);
            m[3:0] = k > 0 ? srcNib(a1, l1, 2 * k - 1) : (neg && (ovf || !zr)) ? 4'hD : 4'hC;
            sh[a2 + 16'(j)] = m;
         end
         runOp({14'h0000, t[1], t[0], 8'h50, 1'h0, r1, 1'h0, r2});
         verify();
      end
      // An undecoded opcode must finish without touching anything
      runOp(32'h0000_0000);
      verify();
      conclude();
   end
endmodule
